// ### rtl/cfe_fwd_engine.sv
// csi-2 forwarding engine: merges four packet buffers onto one transmit stream
// assumes head-of-buffer packet ports on sys_clk, an ahb-lite master, and a
// transmitter byte clock that arrives asynchronously and is only sampled here
`timescale 1ns/1ps
`include "cfe_defs.svh"
module cfe_fwd_engine (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [3:0]  pkt_rdy_i,
  input  wire logic [7:0]  pkt_kind_i,
  input  wire logic [7:0]  pkt_vc_i,
  input  wire logic [23:0] pkt_dt_i,
  input  wire logic [63:0] pkt_wc_i,
  input  wire logic [31:0] byte_i,
  output logic      [3:0]  byte_rd_o,
  output logic      [3:0]  pkt_ack_o,
  input  wire logic        tx_clk_i,
  output logic             tx_hdr_vld_o,
  output logic      [1:0]  tx_kind_o,
  output logic      [1:0]  tx_vc_o,
  output logic      [5:0]  tx_dt_o,
  output logic      [15:0] tx_wc_o,
  output logic             tx_byte_vld_o,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_last_o,
  output logic             sync_o
);
  cfe_pkg::cfe_state_e state_q;
  cfe_pkg::cfe_mode_e  mode_q;
  logic [7:0]  pf_q, fm_q, dp_idx_q, rd_idx;
  logic [15:0] tmo_reg_q, tmo_q, cnt_q, crc_q, tx_wc_q, cat_wc;
  logic [31:0] hrdata_q, rd_val;
  logic        hready_q, hresp_q, dp_wr_q, ap_take, clr_rd;
  logic        lk_s1_q, lk_s2_q, lk_s3_q, lk_edge;
  logic        synced_q, lost_q, lost_set_q, sync_q, quiet;
  logic [1:0]  sel_q, rr_last_q, arb_gnt, p0, tx_kind_q, tx_vc_q;
  logic        arb_any, rr_on, sync_on, heads_match, sel_rdy, sel_en;
  logic [1:0]  sync_sel;
  logic [3:0]  grp_q, cat_q, byte_rd_q, ack_q, en, ready_en, head_fs, nonfs;
  logic [5:0]  tx_dt_q;
  logic [7:0]  tx_byte_q;
  logic        tx_hdr_q, tx_bv_q, tx_last_q;

  function automatic logic [1:0] lowest(input logic [3:0] m);
    lowest = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (m[k]) begin
        lowest = 2'(k);
      end
    end
  endfunction

  function automatic logic [3:0] onehot(input logic [1:0] p);
    onehot = 4'h1 << p;
  endfunction

  function automatic logic [1:0] kind_at(input logic [1:0] p);
    kind_at = pkt_kind_i[2*p +: 2];
  endfunction

  function automatic logic [15:0] wc_at(input logic [1:0] p);
    wc_at = pkt_wc_i[16*p +: 16];
  endfunction

  function automatic logic [7:0] byte_at(input logic [1:0] p);
    byte_at = byte_i[8*p +: 8];
  endfunction

  function automatic logic is_sync(input logic [1:0] k);
    is_sync = (k == `CFE_KIND_FS) || (k == `CFE_KIND_FE);
  endfunction

  // word counts of all ports in the mask; the sum wraps at 16 bits
  function automatic logic [15:0] wc_sum(input logic [3:0] m);
    logic [17:0] s;
    s = 18'h0;
    for (int k = 0; k < 4; k++) begin
      if (m[k]) begin
        s = 18'(s + {2'h0, wc_at(2'(k))});
      end
    end
    wc_sum = s[15:0];
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `CFE_CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  // a port forwards only if not disabled and mapped to this transmitter
  assign en       = ~pf_q[`CFE_PF_DIS_LSB +: 4] & ~pf_q[`CFE_PF_MAP_LSB +: 4];
  assign ready_en = en & pkt_rdy_i;
  assign rr_on    = |fm_q[`CFE_FM_RR_LSB +: 2];
  assign sync_sel = fm_q[`CFE_FM_SYNC_LSB +: 2];
  assign sync_on  = !rr_on && (sync_sel != `CFE_SYNC_OFF);
  assign p0       = lowest(en);
  assign nonfs    = ready_en & ~head_fs;
  assign quiet    = (ack_q == 4'h0) && (byte_rd_q == 4'h0);
  assign lk_edge  = lk_s2_q & ~lk_s3_q;
  assign cat_wc   = wc_sum(cat_q);
  assign sel_rdy  = pkt_rdy_i[sel_q];
  assign sel_en   = en[sel_q];

  // all enabled heads must agree on kind and, for lines and short packets, on length
  always_comb begin
    heads_match = 1'b1;
    head_fs     = 4'h0;
    for (int k = 0; k < 4; k++) begin
      head_fs[k] = kind_at(2'(k)) == `CFE_KIND_FS;
      if (en[k] && (kind_at(2'(k)) != kind_at(p0))) begin
        heads_match = 1'b0;
      end
      if (en[k] && !is_sync(kind_at(p0)) && (wc_at(2'(k)) != wc_at(p0))) begin
        heads_match = 1'b0;
      end
    end
  end

  cfe_rr_arb u_arb (
    .req_i  (ready_en),
    .last_i (rr_last_q),
    .gnt_o  (arb_gnt),
    .any_o  (arb_any)
  );

  // link byte clock is asynchronous: two flops, then edge detect
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      lk_s3_q <= 1'b0;
    end else begin
      lk_s1_q <= tx_clk_i;
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q    <= cfe_pkg::ST_IDLE;
      mode_q     <= cfe_pkg::MODE_RR;
      sel_q      <= 2'h0;
      rr_last_q  <= 2'h3;
      grp_q      <= 4'h0;
      cat_q      <= 4'h0;
      cnt_q      <= 16'h0;
      crc_q      <= `CFE_CRC_INIT;
      tmo_q      <= 16'h0;
      synced_q   <= 1'b0;
      lost_set_q <= 1'b0;
      byte_rd_q  <= 4'h0;
      ack_q      <= 4'h0;
      tx_hdr_q   <= 1'b0;
      tx_bv_q    <= 1'b0;
      tx_last_q  <= 1'b0;
      tx_kind_q  <= 2'h0;
      tx_vc_q    <= 2'h0;
      tx_dt_q    <= 6'h0;
      tx_wc_q    <= 16'h0;
      tx_byte_q  <= 8'h0;
    end else begin
      byte_rd_q  <= 4'h0;
      ack_q      <= 4'h0;
      tx_hdr_q   <= 1'b0;
      tx_bv_q    <= 1'b0;
      tx_last_q  <= 1'b0;
      lost_set_q <= 1'b0;
      case (state_q)
        cfe_pkg::ST_IDLE: begin
          tmo_q <= 16'h0;
          if (quiet && rr_on && arb_any) begin
            mode_q    <= cfe_pkg::MODE_RR;
            sel_q     <= arb_gnt;
            rr_last_q <= arb_gnt;
            grp_q     <= onehot(arb_gnt);
            cat_q     <= onehot(arb_gnt);
            state_q   <= cfe_pkg::ST_HDR;
          end else if (quiet && sync_on) begin
            state_q <= synced_q ? cfe_pkg::ST_GATHER : cfe_pkg::ST_HUNT;
          end
        end
        cfe_pkg::ST_HUNT: begin
          if (!sync_on) begin
            state_q <= cfe_pkg::ST_IDLE;
          end else if (quiet) begin
            if (nonfs != 4'h0) begin
              ack_q <= onehot(lowest(nonfs));
            end else if ((en != 4'h0) && (ready_en == en)) begin
              synced_q <= 1'b1;
              tmo_q    <= 16'h0;
              state_q  <= cfe_pkg::ST_GATHER;
            end else if (ready_en != 4'h0) begin
              if (tmo_q >= tmo_reg_q) begin
                ack_q <= ready_en;
                tmo_q <= 16'h0;
              end else begin
                tmo_q <= 16'(tmo_q + 16'h1);
              end
            end else begin
              tmo_q <= 16'h0;
            end
          end
        end
        cfe_pkg::ST_GATHER: begin
          if (!sync_on) begin
            state_q <= cfe_pkg::ST_IDLE;
          end else if (quiet && (en != 4'h0) && (ready_en == en)) begin
            tmo_q <= 16'h0;
            if (!heads_match) begin
              lost_set_q <= 1'b1;
              synced_q   <= 1'b0;
              state_q    <= cfe_pkg::ST_HUNT;
            end else begin
              sel_q   <= p0;
              state_q <= cfe_pkg::ST_HDR;
              if (sync_sel == `CFE_SYNC_CAT) begin
                mode_q <= cfe_pkg::MODE_CAT;
              end else if (sync_sel == `CFE_SYNC_ILV) begin
                mode_q <= cfe_pkg::MODE_ILV;
              end else begin
                mode_q <= cfe_pkg::MODE_BASIC;
              end
              if (is_sync(kind_at(p0)) && (sync_sel != `CFE_SYNC_BASIC)) begin
                ack_q <= en & ~onehot(p0);
                grp_q <= onehot(p0);
                cat_q <= onehot(p0);
              end else if (sync_sel == `CFE_SYNC_CAT) begin
                grp_q <= en;
                cat_q <= en;
              end else begin
                grp_q <= en;
                cat_q <= onehot(p0);
              end
            end
          end else if (quiet && (ready_en != 4'h0)) begin
            if (tmo_q >= tmo_reg_q) begin
              lost_set_q <= 1'b1;
              synced_q   <= 1'b0;
              tmo_q      <= 16'h0;
              state_q    <= cfe_pkg::ST_HUNT;
            end else begin
              tmo_q <= 16'(tmo_q + 16'h1);
            end
          end else if (quiet) begin
            tmo_q <= 16'h0;
          end
        end
        cfe_pkg::ST_HDR: begin
          if (lk_edge) begin
            tx_hdr_q  <= 1'b1;
            tx_kind_q <= kind_at(sel_q);
            tx_vc_q   <= pkt_vc_i[2*sel_q +: 2];
            tx_dt_q   <= pkt_dt_i[6*sel_q +: 6];
            crc_q     <= `CFE_CRC_INIT;
            cnt_q     <= 16'h0;
            if (kind_at(sel_q) != `CFE_KIND_LINE) begin
              tx_wc_q <= wc_at(sel_q);
              ack_q   <= onehot(sel_q);
              grp_q   <= grp_q & ~onehot(sel_q);
              state_q <= cfe_pkg::ST_NEXT;
            end else begin
              tx_wc_q <= cat_wc;
              if (cat_wc == 16'h0) begin
                ack_q   <= cat_q;
                grp_q   <= grp_q & ~cat_q;
                state_q <= cfe_pkg::ST_FTR0;
              end else begin
                state_q <= cfe_pkg::ST_DATA;
              end
            end
          end
        end
        cfe_pkg::ST_DATA: begin
          if (lk_edge) begin
            tx_bv_q   <= 1'b1;
            tx_byte_q <= byte_at(sel_q);
            byte_rd_q <= onehot(sel_q);
            crc_q     <= crc_byte(crc_q, byte_at(sel_q));
            if (cnt_q == 16'(wc_at(sel_q) - 16'h1)) begin
              ack_q <= onehot(sel_q);
              grp_q <= grp_q & ~onehot(sel_q);
              cat_q <= cat_q & ~onehot(sel_q);
              cnt_q <= 16'h0;
              if ((cat_q & ~onehot(sel_q)) != 4'h0) begin
                sel_q <= lowest(cat_q & ~onehot(sel_q));
              end else begin
                state_q <= cfe_pkg::ST_FTR0;
              end
            end else begin
              cnt_q <= 16'(cnt_q + 16'h1);
            end
          end
        end
        cfe_pkg::ST_FTR0: begin
          if (lk_edge) begin
            tx_bv_q   <= 1'b1;
            tx_byte_q <= crc_q[7:0];
            state_q   <= cfe_pkg::ST_FTR1;
          end
        end
        cfe_pkg::ST_FTR1: begin
          if (lk_edge) begin
            tx_bv_q   <= 1'b1;
            tx_last_q <= 1'b1;
            tx_byte_q <= crc_q[15:8];
            state_q   <= cfe_pkg::ST_NEXT;
          end
        end
        cfe_pkg::ST_NEXT: begin
          if (quiet && (grp_q != 4'h0)) begin
            sel_q   <= lowest(grp_q);
            cat_q   <= onehot(lowest(grp_q));
            state_q <= cfe_pkg::ST_HDR;
          end else if (quiet) begin
            state_q <= (mode_q == cfe_pkg::MODE_RR) ? cfe_pkg::ST_IDLE : cfe_pkg::ST_GATHER;
          end
        end
        default: state_q <= cfe_pkg::ST_IDLE;
      endcase
      if (!sync_on) begin
        synced_q <= 1'b0;
      end
    end
  end

  // status flags; a loss event in the read cycle survives the clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lost_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_q <= synced_q & sync_on;
      if (lost_set_q) begin
        lost_q <= 1'b1;
      end else if (clr_rd) begin
        lost_q <= 1'b0;
      end
    end
  end

  // ahb-lite slave: zero wait states, read data registered in the address phase
  assign ap_take = hsel_i && hready_i && htrans_i[1];
  assign rd_idx  = (haddr_i[31:10] == 22'h0) ? haddr_i[9:2] : `CFE_IDX_NONE;
  assign clr_rd  = ap_take && !hwrite_i && (rd_idx == `CFE_IDX_TX_STS);

  always_comb begin
    rd_val = 32'h0;
    if (rd_idx == `CFE_IDX_PORT_FWD) begin
      rd_val = {24'h0, pf_q};
    end else if (rd_idx == `CFE_IDX_FWD_MODE) begin
      rd_val = {24'h0, fm_q};
    end else if (rd_idx == `CFE_IDX_SYNC_TMO) begin
      rd_val = {16'h0, tmo_reg_q};
    end else if (rd_idx == `CFE_IDX_TX_STS) begin
      rd_val[`CFE_ST_SYNC_BIT] = sync_q;
      rd_val[`CFE_ST_LOST_BIT] = lost_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dp_wr_q  <= 1'b0;
      dp_idx_q <= `CFE_IDX_NONE;
      hrdata_q <= 32'h0;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
      dp_wr_q  <= ap_take && hwrite_i;
      if (ap_take) begin
        dp_idx_q <= rd_idx;
      end
      if (ap_take && !hwrite_i) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // software-visible controls; writes land in the data phase
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pf_q      <= `CFE_PF_RST;
      fm_q      <= `CFE_FM_RST;
      tmo_reg_q <= `CFE_TMO_RST;
    end else if (dp_wr_q) begin
      if (dp_idx_q == `CFE_IDX_PORT_FWD) begin
        pf_q <= hwdata_i[7:0];
      end else if (dp_idx_q == `CFE_IDX_FWD_MODE) begin
        fm_q <= hwdata_i[7:0];
      end else if (dp_idx_q == `CFE_IDX_SYNC_TMO) begin
        tmo_reg_q <= hwdata_i[15:0];
      end
    end
  end

  assign hrdata_o      = hrdata_q;
  assign hreadyout_o   = hready_q;
  assign hresp_o       = hresp_q;
  assign byte_rd_o     = byte_rd_q;
  assign pkt_ack_o     = ack_q;
  assign tx_hdr_vld_o  = tx_hdr_q;
  assign tx_kind_o     = tx_kind_q;
  assign tx_vc_o       = tx_vc_q;
  assign tx_dt_o       = tx_dt_q;
  assign tx_wc_o       = tx_wc_q;
  assign tx_byte_vld_o = tx_bv_q;
  assign tx_byte_o     = tx_byte_q;
  assign tx_last_o     = tx_last_q;
  assign sync_o        = sync_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_sync_off;
    !sync_on ##1 !sync_on;
  endsequence
  sequence s_ftr_start;
    (state_q == cfe_pkg::ST_FTR0) && lk_edge;
  endsequence

  property p_sync_zero;
    s_sync_off |-> !sync_o;
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("sync bit set outside sync mode");

  property p_rd_rdy;
    (byte_rd_o != 4'h0) |-> $past(sel_rdy);
  endproperty
  a_rd_rdy: assert property (p_rd_rdy) else $error("byte pulled from a buffer without a packet");

  property p_rd_en;
    (byte_rd_o != 4'h0) |-> $past(sel_en);
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("byte pulled from a disabled port");

  property p_lost_hold;
    (lost_q && !clr_rd) |=> lost_q;
  endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("loss flag cleared without a read");

  property p_lost_set;
    lost_set_q |=> lost_q;
  endproperty
  a_lost_set: assert property (p_lost_set) else $error("loss event not recorded");

  property p_hunt_quiet;
    (state_q == cfe_pkg::ST_HUNT) ##1 (state_q == cfe_pkg::ST_HUNT) |-> !tx_hdr_vld_o && !tx_byte_vld_o;
  endproperty
  a_hunt_quiet: assert property (p_hunt_quiet) else $error("output while unsynchronized");

  property p_cat_wc;
    (tx_hdr_vld_o && (mode_q == cfe_pkg::MODE_CAT) && (tx_kind_o == `CFE_KIND_LINE))
      |-> tx_wc_o == $past(wc_sum(en));
  endproperty
  a_cat_wc: assert property (p_cat_wc) else $error("joined line length wrong");

  property p_ftr;
    s_ftr_start |=> tx_byte_vld_o ##[2:40] tx_last_o;
  endproperty
  a_ftr: assert property (p_ftr) else $error("footer not completed");
endmodule

// ### rtl/cfe_defs.svh
// constants of the csi-2 forwarding engine: register indices, fields, resets, timing
// included by the engine; holds definitions only
`ifndef CFE_DEFS_SVH
`define CFE_DEFS_SVH
// register indices; the ahb byte address is four times the index
`define CFE_IDX_PORT_FWD 8'h20
`define CFE_IDX_FWD_MODE 8'h21
`define CFE_IDX_SYNC_TMO 8'h22
`define CFE_IDX_TX_STS   8'h35
`define CFE_IDX_NONE     8'hFF
// field positions
`define CFE_PF_DIS_LSB   0
`define CFE_PF_MAP_LSB   4
`define CFE_FM_RR_LSB    0
`define CFE_FM_SYNC_LSB  4
`define CFE_ST_SYNC_BIT  0
`define CFE_ST_LOST_BIT  1
// synchronized-forward select codes
`define CFE_SYNC_OFF     2'h0
`define CFE_SYNC_BASIC   2'h1
`define CFE_SYNC_ILV     2'h2
`define CFE_SYNC_CAT     2'h3
// head packet kinds presented by the buffers
`define CFE_KIND_FS      2'h0
`define CFE_KIND_FE      2'h1
`define CFE_KIND_LINE    2'h2
`define CFE_KIND_SHORT   2'h3
// reset values
`define CFE_PF_RST       8'h00
`define CFE_FM_RST       8'h01
// sync window: about one line period
`define CFE_LINE_TMO_US  30
`define CFE_CLK_MHZ      50
`define CFE_TMO_RST      16'(`CFE_LINE_TMO_US * `CFE_CLK_MHZ)
// packet footer checksum
`define CFE_CRC_INIT     16'hFFFF
`define CFE_CRC_POLY     16'h8408
`endif

// ### rtl/cfe_pkg.sv
// types of the csi-2 forwarding engine
// used by the engine only through scoped names
package cfe_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HUNT, ST_GATHER, ST_HDR, ST_DATA, ST_FTR0, ST_FTR1, ST_NEXT
  } cfe_state_e;
  typedef enum logic [1:0] {MODE_RR, MODE_BASIC, MODE_ILV, MODE_CAT} cfe_mode_e;
endpackage

// ### rtl/cfe_rr_arb.sv
// round-robin choice among four requesting input ports
// combinational; the caller keeps the last grant in a register
`timescale 1ns/1ps
module cfe_rr_arb (
  input  wire logic [3:0] req_i,
  input  wire logic [1:0] last_i,
  output logic      [1:0] gnt_o,
  output logic            any_o
);
  logic [1:0] idx;

  // search starts one past the last grant so no port starves
  always_comb begin
    gnt_o = last_i;
    any_o = 1'b0;
    idx   = last_i;
    for (int k = 1; k <= 4; k++) begin
      idx = 2'(last_i + 2'(k));
      if (!any_o && req_i[idx]) begin
        any_o = 1'b1;
        gnt_o = idx;
      end
    end
  end
endmodule

// ### verif/cfe_rx_model.sv
// downstream receiver model: logs headers and payload, checks packet footers
// assumes one-cycle header and byte pulses from the engine on the core clock
`timescale 1ns/1ps
module cfe_rx_model (
  input  wire logic        sys_clk_i,
  input  wire logic        hdr_vld_i,
  input  wire logic [25:0] hdr_i,
  input  wire logic        byte_vld_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        last_i
);
  logic [25:0] hq[$];
  logic [7:0]  bq[$];
  logic [15:0] crc;
  int          left    = 0;
  int          crc_err = 0;
  always @(posedge sys_clk_i) begin
    if (hdr_vld_i) begin
      // any virtual channel mix is accepted, none is enforced
      hq.push_back(hdr_i);
      crc = 16'hFFFF;
      left = (hdr_i[25:24] == 2'h2) ? int'(hdr_i[15:0]) + 2 : 0;
    end else if (byte_vld_i && left > 0) begin
      if (last_i !== (left == 1)) crc_err++;
      if (left > 2) begin
        bq.push_back(byte_i);
        for (int i = 0; i < 8; i++) begin
          crc = (crc >> 1) ^ ((crc[0] ^ byte_i[i]) ? 16'h8408 : 16'h0000);
        end
      end else if (byte_i !== (left == 2 ? crc[7:0] : crc[15:8])) begin
        crc_err++;
      end
      left--;
    end else if (byte_vld_i || last_i) begin
      crc_err++;
    end
  end
endmodule

// ### verif/csi2_forwarding_engine_test.sv
// bench of the forwarding engine: registers, round robin, three synced modes, loss
// assumes a 50 MHz core clock, a free 160 ns link clock and whole-packet queues
`timescale 1ns/1ps
module csi2_forwarding_engine_test;
  logic        clk = 0, srst = 1, tck = 0, hw = 0, hv, bv, rdo, sy, hrsp, tl;
  logic [1:0]  ht = 0, tk, tv, kd;
  logic [5:0]  tt;
  logic [15:0] tw;
  logic [7:0]  kind = 0, vcs = 0, tb8, eb[$];
  logic [23:0] dts = 0;
  logic [63:0] wcs = 0;
  logic [3:0]  rdy = 0, rd, ack;
  logic [31:0] ha = 0, hwd = 0, hr, r, byt = 0;
  logic [31:0] ra[5] = '{32'h80, 32'h84, 32'h88, 32'hD4, 32'hFC};
  logic [31:0] rv[5] = '{32'h0, 32'h1, 32'h5DC, 32'h0, 32'h0};
  logic [25:0] hd, pq[4][$], eh[$], ph[4][3];
  int          bi[4] = '{0, 0, 0, 0};
  int          mismatches = 0, tests_run = 0, w, d, lo, p0;
  always #10 clk = ~clk;
  always #80 tck = ~tck;
  cfe_fwd_engine dut_u (.sys_clk_i(clk), .srst_i(srst), .hsel_i(1'b1), .haddr_i(ha),
    .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdo),
    .hrdata_o(hr), .hreadyout_o(rdo), .hresp_o(hrsp), .pkt_rdy_i(rdy), .pkt_kind_i(kind),
    .pkt_vc_i(vcs), .pkt_dt_i(dts), .pkt_wc_i(wcs), .byte_i(byt), .byte_rd_o(rd),
    .pkt_ack_o(ack), .tx_clk_i(tck), .tx_hdr_vld_o(hv), .tx_kind_o(tk), .tx_vc_o(tv),
    .tx_dt_o(tt), .tx_wc_o(tw), .tx_byte_vld_o(bv), .tx_byte_o(tb8), .tx_last_o(tl),
    .sync_o(sy));
  cfe_rx_model rx_u (.sys_clk_i(clk), .hdr_vld_i(hv), .hdr_i({tk, tv, tt, tw}),
    .byte_vld_i(bv), .byte_i(tb8), .last_i(tl));
  function automatic logic [7:0] pb(int k, int i);
    return {k[1:0], i[5:0]};
  endfunction
  // head-of-buffer model; an empty buffer shows a junk head, never the old one
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (ack[k] && pq[k].size() > 0) begin
        void'(pq[k].pop_front());
        bi[k] = 0;
      end else if (rd[k]) bi[k]++;
      hd = (pq[k].size() > 0) ? pq[k][0] : 26'h2AAAAAA;
      rdy[k] <= pq[k].size() > 0;
      kind[2*k+:2] <= hd[25:24];
      vcs[2*k+:2] <= hd[23:22];
      dts[6*k+:6] <= hd[21:16];
      wcs[16*k+:16] <= hd[15:0];
      byt[8*k+:8] <= pb(k, bi[k]);
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge clk);
    ht <= 2'h2; ha <= a; hw <= wr;
    do @(posedge clk); while (rdo !== 1'b1 && ++n < 99);
    ht <= 2'h0; hwd <= v;
    do @(posedge clk); while (rdo !== 1'b1 && ++n < 99);
    r = hr;
    chk(hrsp, 0);
    if (n >= 99) begin
      chk(n, 0);
      end_of_test();
    end
  endtask
  task automatic wt(input int n, input logic [3:0] m);
    int c = 0;
    // queued packets reach the ready flags only at the next edges
    repeat (2) @(posedge clk);
    while ((rx_u.hq.size() < n || rx_u.left > 0 || (rdy & m) != 0) && c < 30000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 30000) begin
      chk(c, 0);
      end_of_test();
    end
    repeat (20) @(posedge clk);
  endtask
  task automatic lb(input int k, input int n);
    for (int i = 0; i < n; i++) eb.push_back(pb(k, i));
  endtask
  task automatic pk(input int k, input logic [1:0] t, input int n);
    pq[k].push_back({t, k[1:0], d[5:0], n[15:0]});
  endtask
  task automatic cmp();
    chk(rx_u.hq.size(), eh.size());
    foreach (eh[i]) chk(rx_u.hq[i], eh[i]);
    chk(rx_u.bq.size(), eb.size());
    foreach (eb[i]) chk(rx_u.bq[i], eb[i]);
    chk(rx_u.crc_err, 0);
    eh.delete(); eb.delete(); rx_u.hq.delete(); rx_u.bq.delete();
  endtask
  initial begin
    void'($urandom(32'hEF79));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) begin
      ahb(0, ra[i], 0);
      chk(r, rv[i]);
    end
    ahb(1, 32'hFC, 32'hFFFFFFFF);
    ahb(0, 32'hFC, 0);
    chk(r, 0);
    ahb(1, 32'h88, 32'hFFFF05DC);
    ahb(0, 32'h88, 0);
    chk(r, 32'h5DC);
    d = $urandom_range(60, 16);
    @(negedge clk);
    for (int k = 0; k < 4; k++) for (int j = 0; j < 3; j++) begin
      ph[k][j] = {j ? 2'h2 : 2'h0, 2'(k), 6'(d + j), 16'($urandom_range(8, 1))};
      pq[k].push_back(ph[k][j]);
    end
    wt(12, 4'hF);
    p0 = rx_u.hq[0][23:22];
    for (int i = 0; i < 12; i++) begin
      eh.push_back(ph[(p0 + i) % 4][i / 4]);
      if (i >= 4) lb((p0 + i) % 4, ph[(p0 + i) % 4][i / 4][15:0]);
    end
    cmp();
    for (int m = 1; m < 4; m++) begin
      lo = (m == 3);
      ahb(1, 32'h84, 0);
      ahb(1, 32'h80, lo);
      ahb(1, 32'h84, m << 4);
      w = $urandom_range(8, 1);
      d = $urandom_range(63, 16);
      @(negedge clk);
      // sources aligned and identical in line count and size
      for (int k = 0; k < 4; k++) begin
        pk(k, 0, 1); pk(k, 2, w); pk(k, 2, w); pk(k, 1, 1);
      end
      for (int s = 0; s < 4; s++) begin
        kd = (s == 0) ? 2'h0 : (s == 3) ? 2'h1 : 2'h2;
        if (kd != 2'h2 && m != 1) eh.push_back({kd, 2'(lo), d[5:0], 16'h1});
        else if (m == 3) begin
          eh.push_back({kd, 2'(lo), d[5:0], 16'(3 * w)});
          for (int k = 1; k < 4; k++) lb(k, w);
        end else for (int k = 0; k < 4; k++) begin
          eh.push_back({kd, 2'(k), d[5:0], kd == 2'h2 ? 16'(w) : 16'h1});
          if (kd == 2'h2) lb(k, w);
        end
      end
      wt(eh.size(), lo ? 4'hE : 4'hF);
      chk(sy, 1);
      chk(pq[0].size(), lo ? 4 : 0);
      cmp();
      @(negedge clk);
      pq[0].delete();
    end
    ahb(1, 32'h84, 0);
    ahb(1, 32'h80, 0);
    ahb(1, 32'h84, 32'h10);
    @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      pk(k, 0, 1); pk(k, 2, k == 3 ? w + 1 : w); pk(k, 1, 1);
    end
    wt(0, 4'hF);
    chk(rx_u.hq.size(), 4);
    ahb(0, 32'hD4, 0);
    chk(r[1:0], 2'h2);
    ahb(0, 32'hD4, 0);
    chk(r[1:0], 2'h0);
    @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      pk(k, 0, 1); pk(k, 1, 1);
    end
    wt(0, 4'hF);
    chk(sy, 1);
    ahb(1, 32'h84, 1);
    ahb(0, 32'hD4, 0);
    chk(r[0], 0);
    chk(sy, 0);
    end_of_test();
  end
endmodule
